// *** svwp_packer.sv ***
// Sampler writeback packer with APB configuration slave
module svwp_packer
    import svwp_pkg::*;
(
    input  wire logic                       mclk,
    input  wire logic                       sys_rst,
    input  wire logic                       ce,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [ADDR_W-1:0]          paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       reqValid,
    input  wire svwp_req_t                  reqIn,
    output logic                            reqReady,
    input  wire logic [63:0][3:0][15:0]     pixIn,
    input  wire logic [9:0][15:0][7:0]      lumaIn,
    input  wire logic [9:0][7:0][15:0]      chromaIn,
    input  wire logic [3:0][7:0][7:0]       motionIn,
    input  wire svwp_stat_t                 statIn,
    output svwp_wb_t                        wbOut
);
    svwp_state_t      state_q;
    svwp_req_t        req_q;
    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] mode_q;
    logic [SLOT_W-1:0] slot_q;
    logic [7:0]       dst_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;
    logic             reqReady_q;
    svwp_wb_t         wb_q;
    logic             emit;
    logic             lastNow;
    logic [SLOT_W-1:0] diLen;
    logic [REG_W-1:0] regData;

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign reqReady = reqReady_q;
    assign wbOut    = wb_q;

    function automatic logic [15:0] clampU(input logic [15:0] v);
        return (v > UNORM_ONE) ? UNORM_ONE : v;
    endfunction

    // Highest slot still sent after masking
    function automatic logic [SLOT_W-1:0] hiSlot(input logic [3:0] m);
        logic [1:0] ch;
        ch = 2'h0;
        for (int c = 0; c < 4; c++) begin
            if (!m[c]) begin
                ch = 2'(c);
            end
        end
        return {1'b1, ch, 1'b1};
    endfunction

    function automatic logic [REG_W-1:0] blockReg(input logic [3:0] s);
        logic [REG_W-1:0] r;
        logic [5:0]       p;
        r = '0;
        for (int d = 0; d < DWORDS; d++) begin
            p = {s[3], s[0], d[1], d[2], d[0], 1'b0};
            r[d*32 +: 16]      = clampU(pixIn[p][s[2:1]]);
            r[d*32 + 16 +: 16] = clampU(pixIn[p | 6'h01][s[2:1]]);
        end
        return r;
    endfunction

    function automatic logic [REG_W-1:0] lumaReg(input logic [ROW_W-1:0] rw);
        logic [REG_W-1:0] r;
        r = '0;
        for (int d = 0; d < DWORDS; d++) begin
            for (int b = 0; b < 4; b++) begin
                r[d*32 + b*8 +: 8] =
                    lumaIn[rw + {3'h0, d[2]}][{d[1:0], b[1:0]}];
            end
        end
        return r;
    endfunction

    function automatic logic [REG_W-1:0] chromaReg(input logic [ROW_W-1:0] rw);
        logic [REG_W-1:0] r;
        r = '0;
        for (int d = 0; d < DWORDS; d++) begin
            for (int k = 0; k < 2; k++) begin
                r[d*32 + k*16 +: 16] =
                    chromaIn[rw + {3'h0, d[2]}][{d[1:0], k[0]}];
            end
        end
        return r;
    endfunction

    function automatic logic [REG_W-1:0] motionReg();
        logic [REG_W-1:0] r;
        r = '0;
        for (int d = 0; d < DWORDS; d++) begin
            for (int b = 0; b < 4; b++) begin
                r[d*32 + b*8 +: 8] = motionIn[d[2:1]][{d[0], b[1:0]}];
            end
        end
        return r;
    endfunction

    // Sums and history arrive already computed for the active mode
    function automatic logic [REG_W-1:0] statReg(input logic di,
                                                 input logic dn);
        logic [REG_W-1:0] r;
        logic [31:0]      w [DWORDS];
        w[7] = {statIn.posY, statIn.posX};
        w[6] = statIn.temporalSum;
        w[5] = statIn.horizSum;
        w[4] = statIn.vertSum;
        if (di) begin
            if (!dn) begin
                w[6] = '0;
                w[5] = '0;
                w[4] = '0;
            end
            w[3] = {statIn.topFrameDiff, statIn.botFrameDiff};
            w[2] = {statIn.curTopBotDiff, statIn.curTopPrevBotDiff};
            w[1] = {statIn.curBotPrevTopDiff, statIn.motionCount,
                    dn ? statIn.noiseEst : 8'h00};
            w[0] = statIn.history[3:0];
        end else begin
            w[3] = '0;
            w[2] = {24'h000000, statIn.noiseEst};
            w[1] = statIn.history[7:4];
            w[0] = statIn.history[3:0];
        end
        r = '0;
        for (int d = 0; d < DWORDS; d++) begin
            r[d*32 +: 32] = w[d];
        end
        return r;
    endfunction

    // Partial deinterlace keeps the enabled layout
    always_comb begin
        if (mode_q[CFG_DI_EN] || mode_q[CFG_DI_PART]) begin
            diLen = mode_q[CFG_DN_EN] ? DI_LEN_DN : DI_LEN;
        end else begin
            diLen = mode_q[CFG_IN422] ? ND_LEN_422 : ND_LEN;
        end
    end

    always_comb begin
        if (req_q.kind == SVWP_MSG_BLOCK) begin
            emit    = !req_q.chanMask[slot_q[2:1]];
            lastNow = (slot_q == hiSlot(req_q.chanMask)) ||
                      (slot_q == BLK_LAST_SLOT);
        end else begin
            emit    = slot_q < diLen;
            lastNow = slot_q == SLOT_W'(diLen - 4'h1);
        end
    end

    always_comb begin
        regData = '0;
        if (req_q.kind == SVWP_MSG_BLOCK) begin
            regData = blockReg(slot_q);
        end else if (mode_q[CFG_DI_EN] || mode_q[CFG_DI_PART]) begin
            if (slot_q == DI_MOTION_MEASURE_BLOCK_SLOT) begin
                regData = motionReg();
            end else if (slot_q == DI_STAT_SLOT) begin
                regData = statReg(1'b1, mode_q[CFG_DN_EN]);
            end else if (slot_q == DI_C2L_SLOT) begin
                regData = lumaReg(DI_CUR2_ROW);
            end else if (slot_q > DI_C2L_SLOT) begin
                regData = chromaReg(DI_CUR2_ROW);
            end else if (!slot_q[1]) begin
                // Rows 4-7 hold current first field, denoised on 0 and 2
                regData = lumaReg({1'b0, slot_q[2], slot_q[0], 1'b0});
            end else begin
                regData = chromaReg({1'b0, slot_q[2], slot_q[0], 1'b0});
            end
        end else begin
            if (slot_q < ND_STAT_SLOT) begin
                regData = lumaReg({1'b0, slot_q[1:0], 1'b0});
            end else if (slot_q == ND_STAT_SLOT) begin
                regData = statReg(1'b0, mode_q[CFG_DN_EN]);
            end else begin
                regData = chromaReg({1'b0,
                    2'(slot_q - ND_CHR_SLOT), 1'b0});
            end
        end
    end

    // APB slave, wait state free: answer in first access cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else if (ce) begin
            pready_q <= psel && !penable;
            if (psel && !penable) begin
                pslverr_q <= !(paddr == ADDR_CFG || paddr == ADDR_STAT);
                if (paddr == ADDR_CFG) begin
                    prdata_q <= 32'(cfg_q);
                end else if (paddr == ADDR_STAT) begin
                    prdata_q <= 32'({state_q == SVWP_SEND, cnt_q});
                end else begin
                    prdata_q <= '0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q <= CFG_RST;
        end else if (ce && psel && penable && pready_q && pwrite &&
                     paddr == ADDR_CFG) begin
            cfg_q <= pwdata[CFG_W-1:0];
        end
    end

    // Sequencer: one slot per enabled cycle, masked slots send nothing
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q    <= SVWP_IDLE;
            req_q      <= '0;
            mode_q     <= CFG_RST;
            slot_q     <= '0;
            dst_q      <= '0;
            cnt_q      <= '0;
            reqReady_q <= 1'b1;
        end else if (ce) begin
            unique case (state_q)
                SVWP_IDLE: begin
                    if (reqValid) begin
                        req_q  <= reqIn;
                        mode_q <= cfg_q;
                        slot_q <= '0;
                        dst_q  <= reqIn.dst;
                        cnt_q  <= '0;
                        // Fully masked block request completes silently
                        if (reqIn.kind == SVWP_MSG_DEINT ||
                            reqIn.chanMask != 4'hF) begin
                            state_q    <= SVWP_SEND;
                            reqReady_q <= 1'b0;
                        end
                    end
                end
                SVWP_SEND: begin
                    slot_q <= slot_q + 4'h1;
                    if (emit) begin
                        dst_q <= dst_q + 8'h01;
                        cnt_q <= cnt_q + 5'h01;
                    end
                    if (lastNow) begin
                        state_q    <= SVWP_IDLE;
                        reqReady_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wb_q <= '0;
        end else if (ce) begin
            wb_q.valid <= state_q == SVWP_SEND && emit;
            wb_q.last  <= state_q == SVWP_SEND && lastNow;
            wb_q.dst   <= dst_q;
            wb_q.data  <= regData;
        end
    end
endmodule // svwp_packer

// *** svwp_packer_sva.sv ***
// Checker for writeback order, length and field placement
module svwp_packer_sva
    import svwp_pkg::*;
(
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic              psel,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              reqValid,
    input wire svwp_req_t         reqIn,
    input wire logic              reqReady,
    input wire svwp_stat_t        statIn,
    input wire svwp_wb_t          wbOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cfgQ;
    logic [3:0] modeQ;
    logic [3:0] maskQ;
    logic [7:0] dstQ;
    logic [4:0] cntQ;
    logic [4:0] diLen;
    logic [4:0] blkLen;
    logic       deintQ;
    logic       take;
    logic       over;
    assign take = reqValid && reqReady;
    // Partial deinterlace follows the enabled layout and length
    assign diLen = (modeQ[1:0] != 2'h0) ? (modeQ[2] ? 5'h0C : 5'h0A)
                            : (modeQ[3] ? 5'h09 : 5'h05);
    assign blkLen = 5'(4 * $countones(~maskQ));
    always_comb begin
        over = 1'b0;
        for (int i = 0; i < 16; i++)
            over = over | (wbOut.data[16*i +: 16] > UNORM_ONE);
    end
    // Shadow of the configuration register, so the checker needs no internal probe
    always_ff @(posedge mclk) begin
        if (sys_rst)
            cfgQ <= CFG_RST;
        else if (psel && pready && pwrite && paddr == ADDR_CFG)
            cfgQ <= pwdata[3:0];
    end
    always_ff @(posedge mclk) begin
        if (take) begin
            modeQ <= cfgQ;
            maskQ <= reqIn.chanMask;
            deintQ <= reqIn.kind == SVWP_MSG_DEINT;
            dstQ <= reqIn.dst;
            cntQ <= 5'h00;
        end else if (wbOut.valid) begin
            dstQ <= wbOut.dst + 8'h01;
            cntQ <= cntQ + 5'h01;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    AST_FIRST_SLOT: assert property (take && reqIn.kind == SVWP_MSG_DEINT
        |-> ##2 wbOut.valid && wbOut.dst == $past(reqIn.dst, 2))
        else $error("first register late or misaddressed");
    AST_DST_SEQ: assert property (wbOut.valid |-> wbOut.dst == dstQ)
        else $error("destination not consecutive");
    AST_DI_LEN: assert property (wbOut.valid && deintQ
        |-> wbOut.last == (cntQ + 5'h01 == diLen))
        else $error("deinterlace reply length wrong");
    AST_BLK_LEN: assert property (wbOut.valid && !deintQ
        |-> wbOut.last == (cntQ + 5'h01 == blkLen))
        else $error("block reply length wrong");
    AST_EMPTY: assert property (take && reqIn.chanMask == 4'hF
        && reqIn.kind == SVWP_MSG_BLOCK |=> reqReady && !wbOut.valid
        ##1 !wbOut.valid) else $error("fully masked request sent data");
    AST_CLAMP: assert property (wbOut.valid && !deintQ |-> !over)
        else $error("channel value above one");
    AST_POS: assert property (wbOut.valid && deintQ
        && cntQ == ((modeQ[1:0] != 2'h0) ? 5'h09 : 5'h04)
        |-> wbOut.data[255:224] == {statIn.posY, statIn.posX})
        else $error("block location misplaced");
    AST_DN_OFF: assert property (wbOut.valid && deintQ
        && modeQ[1:0] != 2'h0 && !modeQ[2] && cntQ == 5'h09
        |-> wbOut.data[223:128] == 96'h0
        && wbOut.data[39:32] == 8'h00) else $error("sums not zeroed");
    AST_ND_RSV: assert property (wbOut.valid && deintQ
        && modeQ[1:0] == 2'h0 && cntQ == 5'h04 |-> wbOut.data[127:72] == 56'h0
        && wbOut.data[71:64] == statIn.noiseEst) else $error("reserved bits set");
endmodule // svwp_packer_sva

// *** svwp_packer_tb.sv ***
// Bench for the sampler writeback packer
`define CHK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end \
end
module svwp_packer_tb
    import svwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
    logic reqValid, reqReady, go, gotLast;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [63:0][3:0][15:0] pixIn;
    logic [9:0][15:0][7:0] lumaIn;
    logic [9:0][7:0][15:0] chromaIn;
    logic [3:0][7:0][7:0] motionIn;
    logic [4:0] gotCnt;
    svwp_req_t reqIn, reqCmd;
    svwp_stat_t statIn;
    svwp_wb_t wbOut;
    int err_total, checked;
    svwp_packer svwp_packer_inst (.mclk, .sys_rst, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reqValid,
        .reqIn, .reqReady, .pixIn, .lumaIn, .chromaIn, .motionIn, .statIn,
        .wbOut);
    svwp_thread_model svwp_thread_model_inst (.mclk, .sys_rst, .go,
        .reqCmd, .reqReady, .wbOut, .reqValid, .reqIn, .gotCnt, .gotLast);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Seed FF pushes early pixels above one to hit the clamp
    task automatic fill(input logic [7:0] s);
        for (int i = 0; i < 256; i++) begin
            pixIn[i / 4][i % 4] <= {s ^ 8'(i / 8), 8'(i)};
            if (i < 160) lumaIn[i / 16][i % 16] <= 8'(i * 7) ^ s;
            if (i < 80) chromaIn[i / 8][i % 8] <= 16'(i * 331) ^ {s, 8'h00};
            if (i < 32) motionIn[i / 8][i % 8] <= 8'(i * 13) + s;
            if (i < 36) statIn[8 * i +: 8] <= 8'(i * 5) ^ s;
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] wd, output logic [32:0] r);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            err_total++;
            report_and_stop();
        end
        @(posedge mclk);
    endtask
    task automatic msg(input svwp_msg_t k, input logic [3:0] m,
                       input logic [7:0] d, input int len);
        int n;
        reqCmd <= '{kind: k, chanMask: m, dst: d};
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (gotLast !== 1'b1 && n < 40);
        if (len != 0 && n == 40) begin
            err_total++;
            report_and_stop();
        end
        `CHK(gotCnt, 5'(len))
        `CHK(reqReady, 1'b1)
    endtask
    function automatic logic [REG_W-1:0] expBlk(int h, int c, int r);
        logic [REG_W-1:0] e;
        int p;
        for (int d = 0; d < 8; d++)
            for (int j = 0; j < 2; j++) begin
                p = 32 * h + 16 * r + 2 * (d % 2 + 4 * (d / 2 % 2) + 2 * (d / 4)) + j;
                e[32*d+16*j +: 16] = pixIn[p][c] > UNORM_ONE ? UNORM_ONE : pixIn[p][c];
            end
        return e;
    endfunction
    function automatic logic [REG_W-1:0] expDi(int k, logic [3:0] m);
        logic [REG_W-1:0] e;
        int t;
        int row;
        logic di;
        e = '0;
        // Partial deinterlace shares the enabled layout
        di = m[0] | m[1];
        t = di ? (k == 8 ? 2 : k == 9 ? 3 : k > 9 ? k - 10 : k / 2 % 2)
               : (k == 4 ? 3 : k > 4 ? 1 : 0);
        row = di ? (k > 9 ? 8 : 4 * (k / 4) + 2 * (k % 2))
                 : 2 * (k > 4 ? k - 5 : k);
        for (int d = 0; d < 8; d++)
            for (int b = 0; b < 4; b++)
                case (t)
                    0: e[32*d+8*b +: 8] = lumaIn[row + d / 4][4 * (d % 4) + b];
                    1: if (b < 2) e[32*d+16*b +: 16] = chromaIn[row + d / 4][2 * (d % 4) + b];
                    2: e[32*d+8*b +: 8] = motionIn[d / 2][4 * (d % 2) + b];
                    default: ;
                endcase
        if (t == 3) begin
            e[255:224] = {statIn.posY, statIn.posX};
            if (!di || m[2]) e[223:128] = {statIn.temporalSum, statIn.horizSum, statIn.vertSum};
            if (di) e[127:40] = statIn[159:72];
            if (di && m[2]) e[39:32] = statIn.noiseEst;
            if (!di) e[71:64] = statIn.noiseEst;
            e[63:0] = di ? {32'h0, statIn.history[3:0]} : statIn.history;
        end
        return e;
    endfunction
    task automatic t_apb;
        logic [32:0] r;
        apb(1'b0, ADDR_CFG, 32'h0, r);
        `CHK(r, 33'h0)
        apb(1'b1, 12'h008, 32'h0000000F, r);
        `CHK(r[32], 1'b1)
        apb(1'b0, 12'h008, 32'h0, r);
        `CHK(r, 33'h100000000)
        apb(1'b0, ADDR_CFG, 32'h0, r);
        `CHK(r, 33'h0)
        $display("register access done");
    endtask
    task automatic t_block;
        logic [3:0] masks [4] = '{4'h0, 4'h5, 4'hE, 4'hF};
        int i;
        for (int q = 0; q < 4; q++) begin
            fill(8'(q * 85) ^ 8'hFF);
            msg(SVWP_MSG_BLOCK, masks[q], 8'(q * 70), 16 - 4 * $countones(masks[q]));
            i = 0;
            for (int h = 0; h < 2; h++)
                for (int c = 0; c < 4; c++)
                    for (int r = 0; r < 2 * !masks[q][c]; r++) begin
                        `CHK(svwp_thread_model_inst.got[i], expBlk(h, c, r))
                        i++;
                    end
        end
        $display("block sampling done");
    endtask
    task automatic t_deint;
        logic [3:0] cfgs [6] = '{4'h5, 4'h1, 4'h3, 4'h2, 4'hC, 4'h4};
        int lens [6] = '{12, 10, 10, 10, 9, 5};
        logic [REG_W-1:0] g, e;
        logic [32:0] r;
        for (int q = 0; q < 6; q++) begin
            apb(1'b1, ADDR_CFG, {28'h0, cfgs[q]}, r);
            apb(1'b0, ADDR_CFG, 32'h0, r);
            `CHK(r, {29'h0, cfgs[q]})
            fill(8'(q * 33 + 2));
            msg(SVWP_MSG_DEINT, 4'h0, 8'(q * 16), lens[q]);
            for (int k = 0; k < lens[q]; k++) begin
                g = svwp_thread_model_inst.got[k];
                e = expDi(k, cfgs[q]);
                for (int j = 4; j < 7; j++)
                    if (k == 9 && cfgs[q][1:0] != 2'h0 && cfgs[q][2])
                        g[32*j +: 8] = e[32*j +: 8];
                `CHK(g, e)
            end
            apb(1'b0, ADDR_STAT, 32'h0, r);
            `CHK(r[5:0], 6'(lens[q]))
        end
        $display("deinterlace layouts done");
    endtask
    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = ADDR_CFG;
        pwdata = 32'h0;
        go = 1'b0;
        reqCmd = '0;
        err_total = 0;
        checked = 0;
        fill(8'h00);
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        t_apb();
        t_block();
        t_deint();
        report_and_stop();
    end
endmodule // svwp_packer_tb
bind svwp_packer svwp_packer_sva svwp_packer_sva_inst (.mclk, .sys_rst,
    .psel, .pwrite, .paddr, .pwdata, .pready, .reqValid, .reqIn,
    .reqReady, .statIn, .wbOut);

// *** svwp_pkg.sv ***
// Constants, types and layouts for the sampler writeback packer
// Summary of operation
// - Block sampling reply: up to 16 registers, RGBA for pixels 0-31 then 32-63
// - Masked channel drops its four registers; later channels move down
// - Block pixels numbered row by row, four rows of sixteen
// - Channel values are 16-bit unorm, clamped to 0000h..FF00h
// - Two pixels per dword, higher pixel on top, dword order 0-3,8-11,4-7,12-15
// - Deinterlace layout chosen by deinterlace enable and partial fields
// - Luma register: two rows of sixteen bytes, highest X in top byte
// - Chroma register: Cr/Cb pairs at even X, Cr low byte, two rows
// - Motion register: four rows, X 0-6 low dword, X 8-14 high dword
// - Stats dword 7 holds Y/X; dwords 6-4 sums, zero with deinterlace on and denoise off
// - Dwords 3-1 hold field differences, motion count and noise estimate, noise zero with deinterlace on and denoise off
// - Stats dword 0 holds four history bytes, rows 12-15 on top
// - Deinterlace off: 4x8 sums, dword 3 zero, dword 2 noise only
// - Deinterlace on: 12 registers with denoise, else 10
// - Deinterlace on order: previous field W0-W3, current W4-W7, W8, W9
// - With denoise, current second field luma W10 and chroma W11
// - Current first field rows 0 and 2 carry denoised data
// - Deinterlace off: 9 registers for 4:2:2 input, else 5
// - Deinterlace off: luma W0-W3, stats W4, chroma W5-W8 for 4:2:2
// - Deinterlace off history: dword 1 rows 4-7, dword 0 rows 0-3
// - Deinterlace off luma registers step row index by two
package svwp_pkg;
    localparam int DWORDS      = 8;
    localparam int REG_W       = 256;
    localparam int ADDR_W      = 12;
    localparam int CFG_W       = 4;
    localparam int CNT_W       = 5;
    localparam int SLOT_W      = 4;
    localparam int ROW_W       = 4;

    localparam logic [15:0] UNORM_ONE = 16'hFF00;

    localparam logic [SLOT_W-1:0] BLK_LAST_SLOT = 4'hF;
    localparam logic [SLOT_W-1:0] DI_LEN_DN     = 4'hC;
    localparam logic [SLOT_W-1:0] DI_LEN        = 4'hA;
    localparam logic [SLOT_W-1:0] ND_LEN_422    = 4'h9;
    localparam logic [SLOT_W-1:0] ND_LEN        = 4'h5;
    localparam logic [SLOT_W-1:0] DI_MOTION_MEASURE_BLOCK_SLOT  = 4'h8;
    localparam logic [SLOT_W-1:0] DI_STAT_SLOT  = 4'h9;
    localparam logic [SLOT_W-1:0] DI_C2L_SLOT   = 4'hA;
    localparam logic [SLOT_W-1:0] ND_STAT_SLOT  = 4'h4;
    localparam logic [SLOT_W-1:0] ND_CHR_SLOT   = 4'h5;
    localparam logic [ROW_W-1:0]  DI_CUR2_ROW   = 4'h8;

    localparam logic [ADDR_W-1:0] ADDR_CFG  = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h004;
    localparam logic [CFG_W-1:0]  CFG_RST   = 4'h0;
    localparam int CFG_DI_EN   = 0;
    localparam int CFG_DI_PART = 1;
    localparam int CFG_DN_EN   = 2;
    localparam int CFG_IN422   = 3;

    typedef enum {SVWP_IDLE, SVWP_SEND} svwp_state_t;
    typedef enum logic {SVWP_MSG_BLOCK, SVWP_MSG_DEINT} svwp_msg_t;

    typedef struct packed {
        svwp_msg_t  kind;
        logic [3:0] chanMask;
        logic [7:0] dst;
    } svwp_req_t;

    typedef struct packed {
        logic [15:0]      posY;
        logic [15:0]      posX;
        logic [3:0][7:0]  temporalSum;
        logic [3:0][7:0]  horizSum;
        logic [3:0][7:0]  vertSum;
        logic [15:0]      topFrameDiff;
        logic [15:0]      botFrameDiff;
        logic [15:0]      curTopBotDiff;
        logic [15:0]      curTopPrevBotDiff;
        logic [15:0]      curBotPrevTopDiff;
        logic [7:0]       motionCount;
        logic [7:0]       noiseEst;
        logic [7:0][7:0]  history;
    } svwp_stat_t;

    typedef struct packed {
        logic             valid;
        logic             last;
        logic [7:0]       dst;
        logic [REG_W-1:0] data;
    } svwp_wb_t;
endpackage

// *** svwp_thread_model.sv ***
// Execution thread model: issues one request, gathers its writeback
module svwp_thread_model
    import svwp_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      sys_rst,
    input  wire logic      go,
    input  wire svwp_req_t reqCmd,
    input  wire logic      reqReady,
    input  wire svwp_wb_t  wbOut,
    output logic           reqValid,
    output svwp_req_t      reqIn,
    output logic [4:0]     gotCnt,
    output logic           gotLast
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [REG_W-1:0] got [0:15];
    logic [7:0]       baseQ;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reqValid <= 1'b0;
            reqIn <= '0;
        end else if (go) begin
            reqValid <= 1'b1;
            reqIn <= reqCmd;
            baseQ <= reqCmd.dst;
        end else if (reqValid && reqReady) begin
            reqValid <= 1'b0;
            // Released fields must not look like a stale request
            reqIn <= svwp_req_t'(~reqIn);
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst || go) begin
            gotCnt <= 5'h00;
            gotLast <= 1'b0;
        end else if (wbOut.valid) begin
            got[4'(wbOut.dst - baseQ)] <= wbOut.data;
            gotCnt <= gotCnt + 5'h01;
            gotLast <= wbOut.last;
        end
    end
endmodule // svwp_thread_model
